// ---- logic/msisid_pkg.sv ----
// Package: register map, field layout and transfer types of the MSI and subsystem id block
package msisid_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [11:0] MSISID_OFF_CAPCTL  = 12'h0d0;
  localparam logic [11:0] MSISID_OFF_TGT_LO  = 12'h0d4;
  localparam logic [11:0] MSISID_OFF_TGT_HI  = 12'h0d8;
  localparam logic [11:0] MSISID_OFF_PAYLOAD = 12'h0dc;
  localparam logic [11:0] MSISID_OFF_SIDHDR  = 12'h0f0;
  localparam logic [11:0] MSISID_OFF_SIDVAL  = 12'h0f4;
  // Lock control for the write-lockable fields
  localparam logic [11:0] MSISID_OFF_LOCK    = 12'h0e0;

  // ************************************************************
  // Constant fields and reset values
  // ************************************************************
  localparam logic [7:0]  MSISID_MSI_CAP_ID  = 8'h05;
  localparam logic [7:0]  MSISID_SID_CAP_ID  = 8'h0d;
  localparam logic [7:0]  MSISID_NXT_RST     = 8'h00;
  localparam logic [2:0]  MSISID_MMC_VAL     = 3'h0;
  localparam logic [2:0]  MSISID_GRANT_VAL   = 3'h0;
  localparam logic        MSISID_WIDE_VAL    = 1'b1;
  localparam logic [15:0] MSISID_CODE_RST    = 16'h0000;
  localparam logic [31:0] MSISID_ZERO32      = 32'h0000_0000;
  localparam logic [1:0]  MSISID_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  MSISID_RESP_SLVERR = 2'b10;

  // Field positions in the control word
  localparam int MSISID_EN_BIT   = 16;
  localparam int MSISID_WIDE_BIT = 23;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [63:0] addr;
    logic        wide;
    logic [31:0] data;
  } msisid_msg_type;

  typedef struct packed {
    logic [7:0]  nxt_ptr;
    logic        enable;
    logic [29:0] tgt_lo;
    logic [31:0] tgt_hi;
    logic [15:0] payload;
    logic [7:0]  sid_nxt;
    logic [15:0] maker;
    logic [15:0] board;
    logic        lock;
  } msisid_regs_type;

  typedef enum logic [1:0] {
    MSISID_IDLE = 2'b00,
    MSISID_SEND = 2'b01
  } msisid_state_type;

endpackage

// ---- logic/msisid_wstrb_merge.sv ----
// Byte-lane merge of a write into a stored word
module msisid_wstrb_merge
  import msisid_pkg::*;
#(
  parameter int W = 32
) (
  // Old value and write
  input  wire logic [W-1:0]   old_val,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  // Merged value
  output logic [W-1:0]        new_val
);
  logic [31:0] full;
  always_comb begin
    full = 32'h0;
    full[W-1:0] = old_val;
    for (int i = 0; i < 4; i++) begin
      if (wstrb[i]) begin
        full[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    new_val = full[W-1:0];
  end
endmodule

// ---- logic/msisid_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read in flight
module msisid_axil_slave
  import msisid_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side
  output logic             wr_go,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_hit,
  output logic [11:0]      rd_addr,
  input  wire logic [31:0] rd_val,
  input  wire logic        rd_hit
);
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, rv_r, rv_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;

  assign awready = !aw_r && !b_r;
  assign wready  = !w_r && !b_r;
  assign arready = !rv_r;
  assign wr_go   = aw_r && w_r && !b_r;
  assign wr_addr = awa_r;
  assign wr_data = wd_r;
  assign wr_strb = ws_r;
  assign rd_addr = araddr;
  assign bvalid  = b_r;
  assign bresp   = br_r;
  assign rvalid  = rv_r;
  assign rdata   = rd_r;
  assign rresp   = rr_r;

  always_comb begin
    aw_nxt  = aw_r;
    awa_nxt = awa_r;
    w_nxt   = w_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    b_nxt   = b_r;
    br_nxt  = br_r;
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    if (awvalid && awready) begin
      aw_nxt = 1'b1;
      awa_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_nxt = 1'b1;
      wd_nxt = wdata;
      ws_nxt = wstrb;
    end
    if (wr_go) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      b_nxt = 1'b1;
      br_nxt = wr_hit ? MSISID_RESP_OKAY : MSISID_RESP_SLVERR;
    end else if (b_r && bready) begin
      b_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rv_nxt = 1'b1;
      rd_nxt = rd_hit ? rd_val : MSISID_ZERO32;
      rr_nxt = rd_hit ? MSISID_RESP_OKAY : MSISID_RESP_SLVERR;
    end else if (rv_r && rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_r  <= 1'b0;
      awa_r <= 12'h0;
      w_r   <= 1'b0;
      wd_r  <= 32'h0;
      ws_r  <= 4'h0;
      b_r   <= 1'b0;
      br_r  <= 2'h0;
      rv_r  <= 1'b0;
      rd_r  <= 32'h0;
      rr_r  <= 2'h0;
    end else begin
      aw_r  <= aw_nxt;
      awa_r <= awa_nxt;
      w_r   <= w_nxt;
      wd_r  <= wd_nxt;
      ws_r  <= ws_nxt;
      b_r   <= b_nxt;
      br_r  <= br_nxt;
      rv_r  <= rv_nxt;
      rd_r  <= rd_nxt;
      rr_r  <= rr_nxt;
    end
  end
endmodule

// ---- logic/msisid_top.sv ----
// MSI capability and subsystem identity registers with the message sender
module msisid_top
  import msisid_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write
  input  wire logic [11:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Interrupt event in
  input  wire logic        irq_event,
  // Posted memory write toward the root complex
  output logic             msg_valid,
  input  wire logic        msg_ready,
  output msisid_msg_type   msg
);
  logic            wr_go, wr_hit, rd_hit;
  logic [11:0]     wr_addr, rd_addr;
  logic [31:0]     wr_data, rd_val;
  logic [3:0]      wr_strb;
  logic [31:0]     capctl_rd, tgtlo_rd, payload_rd, sidhdr_rd, sidval_rd;
  logic [31:0]     capctl_m, tgtlo_m, tgthi_m, payload_m, sidhdr_m, sidval_m, lock_m;
  msisid_regs_type regs_r, regs_nxt;
  msisid_state_type st_r, st_nxt;
  msisid_msg_type  msg_r, msg_nxt;
  logic            pend_r, pend_nxt;

  // ************************************************************
  // Bus front end
  // ************************************************************
  msisid_axil_slave u_bus (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .awaddr  (s_awaddr),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .bresp   (s_bresp),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .araddr  (s_araddr),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (wr_hit),
    .rd_addr (rd_addr),
    .rd_val  (rd_val),
    .rd_hit  (rd_hit)
  );

  // ************************************************************
  // Read views
  // ************************************************************
  always_comb begin
    capctl_rd = MSISID_ZERO32;
    capctl_rd[7:0]   = MSISID_MSI_CAP_ID;
    capctl_rd[15:8]  = regs_r.nxt_ptr;
    capctl_rd[MSISID_EN_BIT] = regs_r.enable;
    capctl_rd[19:17] = MSISID_MMC_VAL;
    capctl_rd[22:20] = MSISID_GRANT_VAL;
    capctl_rd[MSISID_WIDE_BIT] = MSISID_WIDE_VAL;
    tgtlo_rd   = {regs_r.tgt_lo, 2'b00};
    payload_rd = {16'h0000, regs_r.payload};
    sidhdr_rd  = {16'h0000, regs_r.sid_nxt, MSISID_SID_CAP_ID};
    sidval_rd  = {regs_r.board, regs_r.maker};
  end

  always_comb begin
    rd_hit = 1'b1;
    case (rd_addr)
      MSISID_OFF_CAPCTL:  rd_val = capctl_rd;
      MSISID_OFF_TGT_LO:  rd_val = tgtlo_rd;
      MSISID_OFF_TGT_HI:  rd_val = regs_r.tgt_hi;
      MSISID_OFF_PAYLOAD: rd_val = payload_rd;
      MSISID_OFF_SIDHDR:  rd_val = sidhdr_rd;
      MSISID_OFF_SIDVAL:  rd_val = sidval_rd;
      MSISID_OFF_LOCK:    rd_val = {31'h0, regs_r.lock};
      default: begin
        rd_val = MSISID_ZERO32;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Write merges
  // ************************************************************
  msisid_wstrb_merge u_m_cap (.old_val(capctl_rd), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(capctl_m));
  msisid_wstrb_merge u_m_lo  (.old_val(tgtlo_rd), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(tgtlo_m));
  msisid_wstrb_merge u_m_hi  (.old_val(regs_r.tgt_hi), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(tgthi_m));
  msisid_wstrb_merge u_m_pl  (.old_val(payload_rd), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(payload_m));
  msisid_wstrb_merge u_m_sh  (.old_val(sidhdr_rd), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(sidhdr_m));
  msisid_wstrb_merge u_m_sv  (.old_val(sidval_rd), .wdata(wr_data), .wstrb(wr_strb),
                              .new_val(sidval_m));
  msisid_wstrb_merge u_m_lk  (.old_val({31'h0, regs_r.lock}), .wdata(wr_data),
                              .wstrb(wr_strb), .new_val(lock_m));

  // Lockable fields only take writes while the lock bit is clear
  always_comb begin
    regs_nxt = regs_r;
    wr_hit   = 1'b1;
    if (wr_go) begin
      case (wr_addr)
        MSISID_OFF_CAPCTL: begin
          if (!regs_r.lock) begin
            regs_nxt.nxt_ptr = capctl_m[15:8];
          end
          regs_nxt.enable = capctl_m[MSISID_EN_BIT];
          // Vector count bits are dropped: one message only
        end
        MSISID_OFF_TGT_LO:  regs_nxt.tgt_lo  = tgtlo_m[31:2];
        MSISID_OFF_TGT_HI:  regs_nxt.tgt_hi  = tgthi_m;
        MSISID_OFF_PAYLOAD: regs_nxt.payload = payload_m[15:0];
        MSISID_OFF_SIDHDR: begin
          if (!regs_r.lock) begin
            regs_nxt.sid_nxt = sidhdr_m[15:8];
          end
        end
        MSISID_OFF_SIDVAL: begin
          if (!regs_r.lock) begin
            regs_nxt.maker = sidval_m[15:0];
            regs_nxt.board = sidval_m[31:16];
          end
        end
        MSISID_OFF_LOCK:    regs_nxt.lock = lock_m[0];
        default:            wr_hit = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Message sender
  // ************************************************************
  // An event with enable set while a message is in flight is remembered once, never dropped
  always_comb begin
    st_nxt   = st_r;
    msg_nxt  = msg_r;
    pend_nxt = pend_r;
    if (irq_event && regs_r.enable) begin
      pend_nxt = 1'b1;
    end
    case (st_r)
      MSISID_IDLE: begin
        if (pend_r) begin
          pend_nxt = irq_event && regs_r.enable;
          st_nxt   = MSISID_SEND;
          msg_nxt.wide = (regs_r.tgt_hi != MSISID_ZERO32);
          msg_nxt.addr = msg_nxt.wide ? {regs_r.tgt_hi, regs_r.tgt_lo, 2'b00}
                                      : {32'h0, regs_r.tgt_lo, 2'b00};
          msg_nxt.data = {16'h0000, regs_r.payload};
        end
      end
      MSISID_SEND: begin
        if (msg_ready) begin
          st_nxt = MSISID_IDLE;
        end
      end
      default: st_nxt = MSISID_IDLE;
    endcase
  end

  assign msg_valid = (st_r == MSISID_SEND);
  assign msg       = msg_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r.nxt_ptr <= MSISID_NXT_RST;
      regs_r.enable  <= 1'b0;
      regs_r.tgt_lo  <= 30'h0;
      regs_r.tgt_hi  <= 32'h0;
      regs_r.payload <= 16'h0;
      regs_r.sid_nxt <= MSISID_NXT_RST;
      regs_r.maker   <= MSISID_CODE_RST;
      regs_r.board   <= MSISID_CODE_RST;
      regs_r.lock    <= 1'b0;
      st_r           <= MSISID_IDLE;
      msg_r          <= '0;
      pend_r         <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
      st_r   <= st_nxt;
      msg_r  <= msg_nxt;
      pend_r <= pend_nxt;
    end
  end
endmodule

// ---- test/msisid_chk.sv ----
// Checker: register read values and message port behaviour of msisid_top
module msisid_chk
  import msisid_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           rst_n,
  // Read channel
  input wire logic [11:0]    s_araddr,
  input wire logic           s_arvalid,
  input wire logic           s_arready,
  input wire logic           s_rvalid,
  input wire logic [31:0]    s_rdata,
  // Message port
  input wire logic           msg_valid,
  input wire logic           msg_ready,
  input wire msisid_msg_type msg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address of the read in flight; arready stays low while rvalid, so it holds
  logic [11:0] rd_a_r;
  logic [11:0] rd_a_nxt;
  always_comb rd_a_nxt = (s_arvalid && s_arready) ? s_araddr : rd_a_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rd_a_r <= 12'h000;
    else rd_a_r <= rd_a_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_cap_id; s_rvalid && rd_a_r == MSISID_OFF_CAPCTL |-> s_rdata[7:0] == 8'h05; endproperty
  a_cap_id: assert property (p_cap_id) else $error("capability id wrong");
  property p_req_vec;
    s_rvalid && rd_a_r == MSISID_OFF_CAPCTL |-> s_rdata[19:17] == 3'h0 && s_rdata[31:24] == 8'h00;
  endproperty
  a_req_vec: assert property (p_req_vec) else $error("requested vectors wrong");
  property p_grant_vec; s_rvalid && rd_a_r == MSISID_OFF_CAPCTL |-> s_rdata[22:20] == 3'h0; endproperty
  a_grant_vec: assert property (p_grant_vec) else $error("granted vectors changed");
  property p_wide_cap; s_rvalid && rd_a_r == MSISID_OFF_CAPCTL |-> s_rdata[23]; endproperty
  a_wide_cap: assert property (p_wide_cap) else $error("wide capable bit low");
  property p_tgt_align; s_rvalid && rd_a_r == MSISID_OFF_TGT_LO |-> s_rdata[1:0] == 2'b00; endproperty
  a_tgt_align: assert property (p_tgt_align) else $error("target low bits set");
  property p_pay_hi; s_rvalid && rd_a_r == MSISID_OFF_PAYLOAD |-> s_rdata[31:16] == 16'h0; endproperty
  a_pay_hi: assert property (p_pay_hi) else $error("payload upper bits set");
  property p_sid_id;
    s_rvalid && rd_a_r == MSISID_OFF_SIDHDR |-> s_rdata[7:0] == 8'h0d && s_rdata[31:16] == 16'h0;
  endproperty
  a_sid_id: assert property (p_sid_id) else $error("identity header wrong");
  property p_narrow; msg_valid && !msg.wide |-> msg.addr[63:32] == 32'h0; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow message with upper address");
  property p_wide; msg_valid && msg.wide |-> msg.addr[63:32] != 32'h0; endproperty
  a_wide: assert property (p_wide) else $error("wide message with zero upper address");
  property p_hold; msg_valid && !msg_ready |=> msg_valid && $stable(msg); endproperty
  a_hold: assert property (p_hold) else $error("message dropped or changed");
  property p_upper; msg_valid |-> msg.data[31:16] == 16'h0 && msg.addr[1:0] == 2'b00; endproperty
  a_upper: assert property (p_upper) else $error("message data or address bits set");
  property p_single; msg_valid && msg_ready |=> !msg_valid; endproperty
  a_single: assert property (p_single) else $error("message repeated");
  c_wide: cover property (msg_valid && msg_ready && msg.wide);
  c_narrow: cover property (msg_valid && msg_ready && !msg.wide);
  c_stall: cover property (msg_valid && !msg_ready);
endmodule

bind msisid_top msisid_chk u_chk (.mclk, .rst_n, .s_araddr, .s_arvalid, .s_arready, .s_rvalid,
  .s_rdata, .msg_valid, .msg_ready, .msg);

// ---- test/msisid_rc_model.sv ----
// Root complex model that accepts posted interrupt writes after a set stall
module msisid_rc_model
  import msisid_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           rst_n,
  // Message port
  input wire logic           msg_valid,
  output logic               msg_ready,
  input wire msisid_msg_type msg,
  // Control and observation
  input wire logic [3:0]     stall,
  output logic [7:0]         rc_count,
  output msisid_msg_type     rc_last
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      msg_ready <= 1'b0;
      wait_r    <= 4'h0;
      rc_count  <= 8'h00;
      rc_last   <= '0;
    end else if (msg_valid && msg_ready) begin
      // Each accepted write counts once
      rc_count  <= rc_count + 8'h01;
      rc_last   <= msg;
      msg_ready <= 1'b0;
      wait_r    <= 4'h0;
    end else if (msg_valid) begin
      wait_r    <= wait_r + 4'h1;
      msg_ready <= (wait_r >= stall);
    end
  end
endmodule

// ---- test/testbench.sv ----
// Testbench: register access over AXI4-Lite and interrupt message delivery
module testbench;
  import msisid_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, irq_event, msg_valid, msg_ready;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0]  s_wstrb, stall;
  logic [1:0]  s_bresp, s_rresp, rs;
  logic [7:0]  rc_count;
  msisid_msg_type msg, rc_last;
  int fail_count = 0;
  int cmp_count = 0;
  logic [11:0] ra [6] = '{12'h0d0, 12'h0d4, 12'h0d8, 12'h0dc, 12'h0f0, 12'h0f4};
  logic [31:0] rst_v [6] = '{32'h0080_0005, 32'h0, 32'h0, 32'h0, 32'h0000_000d, 32'h0};
  logic [31:0] all_v [6] = '{32'h0081_ff05, 32'hffff_fffc, 32'hffff_ffff, 32'h0000_ffff,
                             32'h0000_ff0d, 32'hffff_ffff};
  msisid_top dut (.mclk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .irq_event, .msg_valid, .msg_ready, .msg);
  msisid_rc_model rc (.mclk, .rst_n, .msg_valid, .msg_ready, .msg, .stall, .rc_count, .rc_last);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    r = 2'bxx;
    @(posedge mclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (!aw_ok && s_awready) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid) begin
        r = s_bresp;
        s_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_ok;
    ar_ok = 1'b0;
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (!ar_ok && s_arready) begin
        ar_ok = 1'b1;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid) begin
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
    axi_write(a, d, rs);
    check({30'h0, rs}, {30'h0, MSISID_RESP_OKAY});
    axi_read(a, rd, rs);
    check(rd, exp);
    check({30'h0, rs}, {30'h0, MSISID_RESP_OKAY});
  endtask
  // Pulse one event, then let the message land and msg_valid drop
  task automatic fire(input logic [7:0] exp);
    int n;
    @(posedge mclk);
    irq_event <= 1'b1;
    @(posedge mclk);
    irq_event <= 1'b0;
    for (n = 0; n < 20 && rc_count !== exp; n++) begin
      @(posedge mclk);
    end
    if (n == 20) begin
      fail_count++;
      complete_run();
    end
    // Long enough for a message that must not exist to reach the model at stall 0, not at stall 5
    repeat (6) @(posedge mclk);
    check({24'h0, rc_count}, {24'h0, exp});
  endtask
  task automatic chk_msg(input logic [63:0] a, input logic w, input logic [31:0] d);
    check(rc_last.addr[63:32], a[63:32]);
    check(rc_last.addr[31:0], a[31:0]);
    check({31'h0, rc_last.wide}, {31'h0, w});
    check(rc_last.data, d);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_n <= 1'b0;
    s_awaddr <= 12'h0;
    s_awvalid <= 1'b0;
    s_wdata <= 32'h0;
    s_wstrb <= 4'h0;
    s_wvalid <= 1'b0;
    s_bready <= 1'b0;
    s_araddr <= 12'h0;
    s_arvalid <= 1'b0;
    s_rready <= 1'b0;
    irq_event <= 1'b0;
    stall <= 4'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_read(ra[i], rd, rs);
      check(rd, rst_v[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr_rd(ra[i], 32'hffff_ffff, all_v[i]);
    end
    axi_write(12'h0a0, 32'h1, rs);
    check({30'h0, rs}, {30'h0, MSISID_RESP_SLVERR});
    axi_read(12'h0a0, rd, rs);
    check(rd, 32'h0);
    check({30'h0, rs}, {30'h0, MSISID_RESP_SLVERR});
    axi_write(MSISID_OFF_LOCK, 32'h1, rs);
    wr_rd(12'h0f4, 32'h1234_5678, 32'hffff_ffff);
    wr_rd(12'h0d0, 32'h0001_0000, 32'h0081_ff05);
    axi_write(MSISID_OFF_LOCK, 32'h0, rs);
    wr_rd(12'h0f4, 32'h1234_5678, 32'h1234_5678);
    wr_rd(12'h0d0, 32'h0071_0000, 32'h0081_0005);
    // Target routes to the root port; low bits must drop
    wr_rd(12'h0d4, 32'h0000_1003, 32'h0000_1000);
    wr_rd(12'h0d8, 32'h0, 32'h0);
    wr_rd(12'h0dc, 32'hbeef_abcd, 32'h0000_abcd);
    fire(8'h01);
    chk_msg(64'h0000_1000, 1'b0, 32'h0000_abcd);
    wr_rd(12'h0d8, 32'h0000_0002, 32'h0000_0002);
    stall <= 4'h5;
    fire(8'h02);
    chk_msg(64'h0000_0002_0000_1000, 1'b1, 32'h0000_abcd);
    wr_rd(12'h0d0, 32'h0, 32'h0080_0005);
    fire(8'h02);
    complete_run();
  end
endmodule
